/* File: src/csd_top.sv */
// Clock switch and divider control registers with APB access.
// Assumes irqEvent and monitor inputs are synchronous to core_clk,
// and strap / lock inputs are stable pins.
`timescale 1ns/1ps
module csd_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System inputs
    input wire logic [2:0] strapSource,
    input wire logic failsafeClockMonitor,
    input wire logic irqEvent,
    input wire logic pllLockPin,
    // Clock tree controls
    output logic [2:0] activeSource,
    output logic oscFailTrap,
    output logic [7:0] cpuDivideLog,
    output logic [8:0] fastRcDivide,
    output logic [3:0] pllInputDivide,
    output logic [7:0] pllFeedbackValue
);
    // Pin synchroniser for the PLL lock and strap
    logic lockMeta_q, lockSync_q;
    logic [2:0] strapMeta_q, strapSync_q;
    logic [1:0] strapArm_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockMeta_q <= 1'b0;
            lockSync_q <= 1'b0;
            strapMeta_q <= 3'h0;
            strapSync_q <= 3'h0;
            strapArm_q <= 2'h0;
        end else begin
            lockMeta_q <= pllLockPin;
            lockSync_q <= lockMeta_q;
            strapMeta_q <= strapSource;
            strapSync_q <= strapMeta_q;
            strapArm_q <= {strapArm_q[0], 1'b1};
        end
    end

    // reserved code maps to fast RC
    function automatic logic [2:0] mapSource(input logic [2:0] code);
        mapSource = (code == csd_pkg::SRC_RSVD) ? csd_pkg::SRC_FRC : code;
    endfunction

    logic apbWrite, apbRead;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && penable && !pwrite;

    // State registers
    csd_pkg::csd_unlock_e unlHi_q, unlHi_d, unlLo_q, unlLo_d;
    csd_pkg::csd_switch_e sw_q, sw_d;
    logic [3:0] swCnt_q, swCnt_d;
    logic [2:0] cur_q, cur_d, new_q, new_d;
    logic fail_q, fail_d, swReq_q, swReq_d, lockEn_q, lockEn_d;
    logic roi_q, roi_d, strapDone_q, strapDone_d;
    csd_pkg::csd_cfg_s cfg_q, cfg_d;
    logic [31:0] rdata_d;
    logic accessDone_q;

    always_comb begin
        unlHi_d = unlHi_q;
        unlLo_d = unlLo_q;
        sw_d = sw_q;
        swCnt_d = swCnt_q;
        cur_d = cur_q;
        new_d = new_q;
        fail_d = fail_q;
        // Completion clears first so a fresh software request wins
        swReq_d = (sw_q == csd_pkg::SW_RUN) ? 1'b0 : swReq_q;
        lockEn_d = lockEn_q;
        roi_d = roi_q;
        cfg_d = cfg_q;
        strapDone_d = strapDone_q | strapArm_q[1];
        // Strap captured once, after the synchroniser has filled
        if (!strapDone_q && strapArm_q[1]) begin
            cur_d = mapSource(strapSync_q);
            new_d = strapSync_q;
        end
        if (apbWrite && paddr == csd_pkg::ADDR_OSC_CTRL) begin
            if (pstrb[1]) begin
                if (unlHi_q == csd_pkg::UNL_OPEN) begin
                    new_d = pwdata[csd_pkg::NEW_LSB +: 3];
                    unlHi_d = csd_pkg::UNL_IDLE;
                end else if (unlHi_q == csd_pkg::UNL_KEY1 &&
                             pwdata[15:8] == csd_pkg::KEY_HI_2) begin
                    unlHi_d = csd_pkg::UNL_OPEN;
                end else if (pwdata[15:8] == csd_pkg::KEY_HI_1) begin
                    unlHi_d = csd_pkg::UNL_KEY1;
                end else begin
                    unlHi_d = csd_pkg::UNL_IDLE;
                end
            end
            if (pstrb[0]) begin
                if (unlLo_q == csd_pkg::UNL_OPEN) begin
                    lockEn_d = pwdata[csd_pkg::LOCKEN_BIT];
                    fail_d = pwdata[csd_pkg::FAIL_BIT];
                    if (pwdata[csd_pkg::SWREQ_BIT]) begin
                        swReq_d = 1'b1;
                    end
                    unlLo_d = csd_pkg::UNL_IDLE;
                end else if (unlLo_q == csd_pkg::UNL_KEY1 &&
                             pwdata[7:0] == csd_pkg::KEY_LO_2) begin
                    unlLo_d = csd_pkg::UNL_OPEN;
                end else if (pwdata[7:0] == csd_pkg::KEY_LO_1) begin
                    unlLo_d = csd_pkg::UNL_KEY1;
                end else begin
                    unlLo_d = csd_pkg::UNL_IDLE;
                end
            end
        end else if (apbWrite) begin
            // Any write to another register breaks both pending unlocks
            unlHi_d = csd_pkg::UNL_IDLE;
            unlLo_d = csd_pkg::UNL_IDLE;
        end
        if (apbWrite && paddr == csd_pkg::ADDR_CLK_DIV) begin
            if (pstrb[1]) begin
                roi_d = pwdata[csd_pkg::ROI_BIT];
                if (!cfg_q.dozeOn) begin
                    cfg_d.dozeRatio = pwdata[csd_pkg::DOZE_LSB +: 3];
                end
                if (!pwdata[csd_pkg::REDUCTION_ENABLE_BIT] ||
                    cfg_d.dozeRatio != csd_pkg::DOZE_ZERO) begin
                    cfg_d.dozeOn = pwdata[csd_pkg::REDUCTION_ENABLE_BIT];
                end
                cfg_d.fastRcPostscaler = pwdata[csd_pkg::FRCPS_LSB +: 3];
            end
            if (pstrb[0]) begin
                cfg_d.pllPrescaler = pwdata[csd_pkg::PRE_LSB +: 4];
            end
        end
        if (apbWrite && paddr == csd_pkg::ADDR_PLL_FBD && pstrb[0]) begin
            cfg_d.pllFeedbackValue = pwdata[7:0];
        end
        if (roi_q && irqEvent) begin
            cfg_d.dozeOn = 1'b0;
        end
        // monitor sets, set wins over clear
        if (failsafeClockMonitor) begin
            fail_d = 1'b1;
        end
        case (sw_q)
            csd_pkg::SW_IDLE: begin
                if (swReq_q) begin
                    sw_d = csd_pkg::SW_STOP;
                    swCnt_d = 4'h0;
                end
            end
            csd_pkg::SW_STOP: begin
                // Old clock gated off for a full window before handover
                swCnt_d = swCnt_q + 4'h1;
                if (swCnt_q == csd_pkg::SWITCH_CYCLES - 4'h1) begin
                    cur_d = mapSource(new_q);
                    sw_d = csd_pkg::SW_RUN;
                end
            end
            csd_pkg::SW_RUN: begin
                sw_d = csd_pkg::SW_IDLE;
            end
            default: sw_d = csd_pkg::SW_IDLE;
        endcase
    end

    // Read mux
    always_comb begin
        rdata_d = 32'h0;
        case (paddr)
            csd_pkg::ADDR_OSC_CTRL: begin
                rdata_d[csd_pkg::CUR_LSB +: 3] = cur_q;
                rdata_d[csd_pkg::NEW_LSB +: 3] = new_q;
                rdata_d[csd_pkg::LOCKEN_BIT] = lockEn_q;
                rdata_d[csd_pkg::PLLLOCK_BIT] = lockSync_q;
                rdata_d[csd_pkg::FAIL_BIT] = fail_q;
                rdata_d[csd_pkg::SWREQ_BIT] = swReq_q;
            end
            csd_pkg::ADDR_CLK_DIV: begin
                rdata_d[csd_pkg::ROI_BIT] = roi_q;
                rdata_d[csd_pkg::DOZE_LSB +: 3] = cfg_q.dozeRatio;
                rdata_d[csd_pkg::REDUCTION_ENABLE_BIT] = cfg_q.dozeOn;
                rdata_d[csd_pkg::FRCPS_LSB +: 3] = cfg_q.fastRcPostscaler;
                rdata_d[csd_pkg::PRE_LSB +: 4] = cfg_q.pllPrescaler;
            end
            csd_pkg::ADDR_PLL_FBD: rdata_d[7:0] = cfg_q.pllFeedbackValue;
            csd_pkg::ADDR_CLK_STAT: rdata_d[1:0] = {sw_q != csd_pkg::SW_IDLE,
                                                    strapDone_q};
            default: rdata_d = 32'h0;
        endcase
    end

    // No wait state: setup, access, pready high in the first access cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlHi_q <= csd_pkg::UNL_IDLE;
            unlLo_q <= csd_pkg::UNL_IDLE;
            sw_q <= csd_pkg::SW_IDLE;
            swCnt_q <= 4'h0;
            cur_q <= csd_pkg::SRC_FRC;
            new_q <= csd_pkg::SRC_FRC;
            fail_q <= 1'b0;
            swReq_q <= 1'b0;
            lockEn_q <= 1'b0;
            roi_q <= 1'b0;
            strapDone_q <= 1'b0;
            cfg_q <= '{dozeOn: 1'b0, dozeRatio: csd_pkg::DOZE_RESET,
                       fastRcPostscaler: csd_pkg::FRCPS_RESET,
                       pllPrescaler: csd_pkg::PRE_RESET,
                       pllFeedbackValue: csd_pkg::FBD_RESET};
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            accessDone_q <= 1'b0;
        end else begin
            unlHi_q <= unlHi_d;
            unlLo_q <= unlLo_d;
            sw_q <= sw_d;
            swCnt_q <= swCnt_d;
            cur_q <= cur_d;
            new_q <= new_d;
            fail_q <= fail_d;
            swReq_q <= swReq_d;
            lockEn_q <= lockEn_d;
            roi_q <= roi_d;
            strapDone_q <= strapDone_d;
            cfg_q <= cfg_d;
            accessDone_q <= 1'b0;
            prdata <= apbRead ? rdata_d : 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pready <= 1'b1;
                pslverr <= paddr > csd_pkg::ADDR_CLK_STAT || paddr[1:0] != 2'h0;
                prdata <= pwrite ? 32'h0 : rdata_d;
            end
        end
    end

    // Clock tree outputs, all registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeSource <= csd_pkg::SRC_FRC;
            oscFailTrap <= 1'b0;
            cpuDivideLog <= 8'h0;
            fastRcDivide <= 9'h1;
            pllInputDivide <= csd_pkg::PRE_RESET;
            pllFeedbackValue <= csd_pkg::FBD_RESET;
        end else begin
            activeSource <= cur_q;
            // trap follows the flag whoever set it
            oscFailTrap <= fail_q;
            cpuDivideLog <= cfg_q.dozeOn ? 8'h1 << cfg_q.dozeRatio : 8'h1;
            // postscaler code seven divides by 256
            fastRcDivide <= (cfg_q.fastRcPostscaler == 3'h7) ? 9'h100 :
                            9'h1 << cfg_q.fastRcPostscaler;
            // reserved prescaler codes hold last legal
            if (cfg_q.pllPrescaler != 4'h0 &&
                cfg_q.pllPrescaler <= csd_pkg::PRE_MAX) begin
                pllInputDivide <= cfg_q.pllPrescaler;
            end
            pllFeedbackValue <= cfg_q.pllFeedbackValue;
        end
    end

    chk_doze_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg_q.dozeOn |-> cfg_q.dozeRatio != csd_pkg::DOZE_ZERO)
        else $error("doze enabled with zero ratio");
    chk_roi_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        roi_q && irqEvent |=> !cfg_q.dozeOn)
        else $error("interrupt did not clear doze enable");
    chk_doze_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg_q.dozeOn |=> $stable(cfg_q.dozeRatio))
        else $error("doze field changed while enabled");
    chk_fail_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        failsafeClockMonitor |=> fail_q ##1 oscFailTrap)
        else $error("failure not flagged");
    chk_fail_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        fail_q && !apbWrite |=> fail_q)
        else $error("fail flag cleared by hardware");
    chk_switch_done: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(swReq_q) |-> ##[9:11] !swReq_q)
        else $error("switch request not completed");
    chk_switch_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(swReq_q) |-> cur_q == mapSource(new_q))
        else $error("current source not updated");
    chk_ratio_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cfg_q.dozeOn |=> cpuDivideLog == 8'h1)
        else $error("ratio not forced to one");
endmodule

/* File: src/csd_pkg.sv */
// Package for the clock switch and divider control block.
// Assumes an APB slave with 32-bit data; registers hold 16 bits.
package csd_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CLK_DIV = 12'h004;
    localparam logic [11:0] ADDR_PLL_FBD = 12'h008;
    localparam logic [11:0] ADDR_CLK_STAT = 12'h00c;

    // Oscillator control field positions
    localparam int CUR_LSB = 12;
    localparam int NEW_LSB = 8;
    localparam int FAIL_BIT = 3;
    localparam int SWREQ_BIT = 0;
    localparam int LOCKEN_BIT = 7;
    localparam int PLLLOCK_BIT = 5;

    // Clock divider field positions
    localparam int ROI_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int REDUCTION_ENABLE_BIT = 11;
    localparam int FRCPS_LSB = 8;
    localparam int PRE_LSB = 0;

    // Unlock keys
    localparam logic [7:0] KEY_HI_1 = 8'h78;
    localparam logic [7:0] KEY_HI_2 = 8'h9a;
    localparam logic [7:0] KEY_LO_1 = 8'h46;
    localparam logic [7:0] KEY_LO_2 = 8'h57;

    // Reset values, prescaler maximum and zero doze code
    localparam logic [2:0] DOZE_RESET = 3'h3;
    localparam logic [2:0] FRCPS_RESET = 3'h0;
    localparam logic [3:0] PRE_RESET = 4'h1;
    localparam logic [3:0] PRE_MAX = 4'h8;
    localparam logic [7:0] FBD_RESET = 8'h96;
    localparam logic [2:0] DOZE_ZERO = 3'h0;

    // Source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_WITH_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRIPLL = 3'h3;
    localparam logic [2:0] SRC_RSVD = 3'h4;

    // Switch handover length in cycles
    localparam logic [3:0] SWITCH_CYCLES = 4'h8;

    typedef enum {UNL_IDLE, UNL_KEY1, UNL_OPEN} csd_unlock_e;
    typedef enum {SW_IDLE, SW_STOP, SW_RUN} csd_switch_e;

    typedef struct packed {
        logic dozeOn;
        logic [2:0] dozeRatio;
        logic [2:0] fastRcPostscaler;
        logic [3:0] pllPrescaler;
        logic [7:0] pllFeedbackValue;
    } csd_cfg_s;
endpackage

/* File: tb/csd_top_tb_top.sv */
// Self-checking bench for the clock switch and divider control block.
// Drives the APB port and the system inputs directly; no partner model.
`timescale 1ns/1ps
module csd_top_tb_top;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic [3:0] pstrb, pllInputDivide;
    logic [2:0] strapSource, activeSource;
    logic failsafeClockMonitor, irqEvent, pllLockPin, oscFailTrap, errVal;
    logic [7:0] cpuDivideLog, pllFeedbackValue;
    logic [8:0] fastRcDivide;
    logic [2:0] srcList [8] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h1, 3'h0, 3'h3,
                                3'h0};
    logic [2:0] expSrc;
    logic [31:0] v;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    csd_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strapSource(strapSource), .failsafeClockMonitor(failsafeClockMonitor),
        .irqEvent(irqEvent), .pllLockPin(pllLockPin),
        .activeSource(activeSource), .oscFailTrap(oscFailTrap),
        .cpuDivideLog(cpuDivideLog), .fastRcDivide(fastRcDivide),
        .pllInputDivide(pllInputDivide), .pllFeedbackValue(pllFeedbackValue));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("errors %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is sampled high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdVal = prdata;
        errVal = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(rdVal, exp);
    endtask

    task automatic osc_hi(input logic [7:0] val);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {16'h0, csd_pkg::KEY_HI_1, 8'h0}, 4'h2);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {16'h0, csd_pkg::KEY_HI_2, 8'h0}, 4'h2);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {16'h0, val, 8'h0}, 4'h2);
    endtask

    task automatic osc_lo(input logic [7:0] val);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {24'h0, csd_pkg::KEY_LO_1}, 4'h1);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {24'h0, csd_pkg::KEY_LO_2}, 4'h1);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {24'h0, val}, 4'h1);
    endtask

    task automatic wr_div(input logic [31:0] d);
        xfer(1'b1, csd_pkg::ADDR_CLK_DIV, d, 4'h3);
    endtask

    task automatic pulse_irq();
        @(posedge core_clk);
        irqEvent <= 1'b1;
        @(posedge core_clk);
        irqEvent <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {failsafeClockMonitor, irqEvent} = '0;
        strapSource = 3'h2;
        pllLockPin = 1'b1;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(32'(pllFeedbackValue), 32'd150);
        chk(32'(fastRcDivide), 32'h1);
        chk(32'(pllInputDivide), 32'h1);
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'h3001);
        rd_chk(csd_pkg::ADDR_PLL_FBD, 32'h0096);
        rd_chk(csd_pkg::ADDR_OSC_CTRL, 32'h2220);
        chk(32'(activeSource), 32'h2);
        rd_chk(csd_pkg::ADDR_CLK_STAT, 32'h1);
        xfer(1'b0, 12'h010, 32'h0, 4'h0);
        chk(32'(errVal), 32'h1);
        chk(rdVal, 32'h0);
        xfer(1'b1, csd_pkg::ADDR_PLL_FBD, 32'hff64, 4'h3);
        rd_chk(csd_pkg::ADDR_PLL_FBD, 32'h0064);
        chk(32'(pllFeedbackValue), 32'd100);
        wr_div(32'h00f1);
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'h0001);
        wr_div(32'h0801);
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'h0001);
        // Doze cleared between codes, otherwise the field write is dropped
        for (int i = 1; i < 8; i++) begin
            v = (i << 12) | (i << 8) | (i + 1);
            wr_div(v);
            wr_div(v | 32'h0800);
            repeat (3) @(posedge core_clk);
            chk(32'(cpuDivideLog), 32'h1 << i);
            chk(32'(fastRcDivide), (i == 7) ? 32'd256 : 32'h1 << i);
            chk(32'(pllInputDivide), 32'(i + 1));
            wr_div(v);
            repeat (3) @(posedge core_clk);
            chk(32'(cpuDivideLog), 32'h1);
        end
        wr_div(32'h7700);
        wr_div(32'h7709);
        repeat (3) @(posedge core_clk);
        chk(32'(pllInputDivide), 32'h8);
        wr_div(32'h5801);
        wr_div(32'h2801);
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'h5801);
        pulse_irq();
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'h5801);
        chk(32'(cpuDivideLog), 32'd32);
        wr_div(32'hd801);
        pulse_irq();
        rd_chk(csd_pkg::ADDR_CLK_DIV, 32'hd001);
        chk(32'(cpuDivideLog), 32'h1);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, 32'h0500, 4'h2);
        rd_chk(csd_pkg::ADDR_OSC_CTRL, 32'h2220);
        // plain fast RC sits between the two PLL modes in this list
        for (int k = 0; k < 8; k++) begin
            osc_hi({5'h0, srcList[k]});
            osc_lo(8'h01);
            xfer(1'b0, csd_pkg::ADDR_OSC_CTRL, 32'h0, 4'h0);
            chk(32'(rdVal[0]), 32'h1);
            rd_chk(csd_pkg::ADDR_CLK_STAT, 32'h3);
            // Reserved code four runs on plain fast RC
            expSrc = (srcList[k] == 3'h4) ? 3'h0 : srcList[k];
            // Poll until the request bit reads back clear
            for (int n = 0; n < 20 && rdVal[0] !== 1'b0; n++)
                xfer(1'b0, csd_pkg::ADDR_OSC_CTRL, 32'h0, 4'h0);
            chk(32'(activeSource), 32'(expSrc));
            v = {17'h0, expSrc, 1'b0, srcList[k], 8'h20};
            rd_chk(csd_pkg::ADDR_OSC_CTRL, v);
        end
        @(posedge core_clk);
        failsafeClockMonitor <= 1'b1;
        @(posedge core_clk);
        failsafeClockMonitor <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'(oscFailTrap), 32'h1);
        repeat (20) @(posedge core_clk);
        rd_chk(csd_pkg::ADDR_OSC_CTRL, 32'h0028);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {24'h0, csd_pkg::KEY_LO_1}, 4'h1);
        wr_div(32'hd001);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, {24'h0, csd_pkg::KEY_LO_2}, 4'h1);
        xfer(1'b1, csd_pkg::ADDR_OSC_CTRL, 32'h0, 4'h1);
        rd_chk(csd_pkg::ADDR_OSC_CTRL, 32'h0028);
        osc_lo(8'h00);
        repeat (3) @(posedge core_clk);
        chk(32'(oscFailTrap), 32'h0);
        osc_lo(8'h08);
        repeat (3) @(posedge core_clk);
        chk(32'(oscFailTrap), 32'h1);
        rd_chk(csd_pkg::ADDR_OSC_CTRL, 32'h0028);
        wrap_up();
    end
endmodule
